// File: hdl/ccsc_regs.vh
// ccsc_regs.vh: register offsets, field positions and timing for the crate controller
// assumes an included-once header; every user includes it by bare name
`ifndef CCSC_REGS_VH
`define CCSC_REGS_VH

// ----------------------------------------------------------------
// register offsets (host i/o space, 4 address bits)
// ----------------------------------------------------------------
`define CCSC_OFS_WDATA_LOW   4'h0
`define CCSC_OFS_WDATA_MID   4'h1
`define CCSC_OFS_WDATA_HIGH  4'h2
`define CCSC_OFS_STATION     4'h3
`define CCSC_OFS_SUBADDR     4'h4
`define CCSC_OFS_FUNCTION    4'h5
`define CCSC_OFS_RDATA_LOW   4'h6
`define CCSC_OFS_RDATA_MID   4'h7
`define CCSC_OFS_RDATA_HIGH  4'h8
`define CCSC_OFS_STATUS      4'h9
`define CCSC_OFS_ZCI_CMD     4'ha
`define CCSC_OFS_LAM         4'hb
`define CCSC_OFS_BLK_COUNT   4'hc
`define CCSC_OFS_BLK_START   4'hd
`define CCSC_OFS_BLK_STATUS  4'he

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CCSC_ST_Q            0
`define CCSC_ST_X            1
`define CCSC_ST_BLK_BUSY     2
`define CCSC_ST_BLK_DONE     3
`define CCSC_ST_LAM          4
`define CCSC_ST_INHIBIT      5
`define CCSC_ZCI_Z           0
`define CCSC_ZCI_C           1
`define CCSC_ZCI_I           2

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CCSC_RST_BYTE        8'h00
`define CCSC_RST_BLK_COUNT   8'h01

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CCSC_CLK_NS          10
`define CCSC_STEP_NS         100
`define CCSC_NORM_NS         1000
`define CCSC_COMP_NS         800

`endif

// File: hdl/ccsc_norm_seq.v
// ccsc_norm_seq: normal dataway cycle sequencer, ten steps of 100 ns
// assumes start is a one-cycle pulse from logic on mclk, given only while idle
`timescale 1ns/100ps
`include "ccsc_regs.vh"

module ccsc_norm_seq #(
  parameter STEP_CYC = 10,
  parameter N_STEPS  = 10
) (
  // clock and reset
  input  wire mclk,
  input  wire reset,
  // control
  input  wire start,
  input  wire wr_fn,
  // dataway timing
  output reg  busy_ff,
  output reg  s1_ff,
  output reg  s2_ff,
  output reg  naf_oe_ff,
  output reg  wd_oe_ff,
  output reg  latch_ff,
  output reg  done_ff
);

  localparam ST_IDLE = 2'b01;
  localparam ST_RUN  = 2'b10;

  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg [7:0] pre_ff;
  reg [7:0] nxt_pre;
  reg [3:0] step_ff;
  reg [3:0] nxt_step;
  reg       wr_ff;
  wire      run;
  wire      step_end;

  function in_rng;
    input [3:0] s;
    input [3:0] lo;
    input [3:0] hi;
    begin
      in_rng = (s >= lo) && (s <= hi);
    end
  endfunction

  assign run      = state_ff[1];
  assign step_end = (pre_ff == STEP_CYC[7:0] - 8'h01);

  // ----------------------------------------------------------------
  // step counter, advances once per 100 ns
  // ----------------------------------------------------------------
  always @* begin
    nxt_state = state_ff;
    nxt_pre   = pre_ff;
    nxt_step  = step_ff;
    case (state_ff)
      ST_IDLE: begin
        nxt_pre  = 8'h00;
        nxt_step = 4'h0;
        if (start) begin
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        nxt_pre = step_end ? 8'h00 : pre_ff + 8'h01; // R4
        if (step_end) begin
          nxt_step = step_ff + 4'h1;
          if (step_ff == N_STEPS[3:0] - 4'h1) begin
            nxt_state = ST_IDLE; // R3
          end
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_ff  <= ST_IDLE;
      pre_ff    <= 8'h00;
      step_ff   <= 4'h0;
      wr_ff     <= 1'b0;
      busy_ff   <= 1'b0;
      s1_ff     <= 1'b0;
      s2_ff     <= 1'b0;
      naf_oe_ff <= 1'b0;
      wd_oe_ff  <= 1'b0;
      latch_ff  <= 1'b0;
      done_ff   <= 1'b0;
    end else begin
      state_ff  <= nxt_state;
      pre_ff    <= nxt_pre;
      step_ff   <= nxt_step;
      if (start) begin
        wr_ff <= wr_fn;
      end
      // dataway signals from the current step
      busy_ff   <= run && in_rng(step_ff, 4'h0, 4'h8); // R3
      naf_oe_ff <= run && in_rng(step_ff, 4'h0, 4'h8); // R3
      wd_oe_ff  <= run && wr_ff && in_rng(step_ff, 4'h0, 4'h8);
      s1_ff     <= run && in_rng(step_ff, 4'h2, 4'h3); // R3
      s2_ff     <= run && in_rng(step_ff, 4'h6, 4'h7); // R3
      latch_ff  <= run && step_end && (step_ff == 4'h3);
      done_ff   <= run && step_end && (step_ff == N_STEPS[3:0] - 4'h1);
    end
  end

endmodule

// File: hdl/ccsc_comp_seq.v
// ccsc_comp_seq: compressed dataway cycle sequencer, eight steps of 100 ns
// assumes start is a one-cycle pulse from logic on mclk, given only while idle
`timescale 1ns/100ps
`include "ccsc_regs.vh"

module ccsc_comp_seq #(
  parameter STEP_CYC = 10,
  parameter N_STEPS  = 8
) (
  // clock and reset
  input  wire       mclk,
  input  wire       reset,
  // control
  input  wire       start,
  input  wire [1:0] zc_sel,
  // dataway timing
  output reg        busy_ff,
  output reg        s2_ff,
  output reg        z_ff,
  output reg        c_ff,
  output reg        done_ff
);

  localparam ST_IDLE = 2'b01;
  localparam ST_RUN  = 2'b10;

  reg [1:0] state_ff;
  reg [7:0] pre_ff;
  reg [3:0] step_ff;
  reg [1:0] sel_ff;
  wire      run;
  wire      step_end;
  wire      zc_win;

  assign run      = state_ff[1];
  assign step_end = (pre_ff == STEP_CYC[7:0] - 8'h01);
  assign zc_win   = run && (step_ff >= 4'h1) && (step_ff <= 4'h6);

  // ----------------------------------------------------------------
  // sequencer and dataway outputs
  // ----------------------------------------------------------------
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_ff <= ST_IDLE;
      pre_ff   <= 8'h00;
      step_ff  <= 4'h0;
      sel_ff   <= 2'b00;
      busy_ff  <= 1'b0;
      s2_ff    <= 1'b0;
      z_ff     <= 1'b0;
      c_ff     <= 1'b0;
      done_ff  <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          pre_ff  <= 8'h00;
          step_ff <= 4'h0;
          if (start) begin
            sel_ff   <= zc_sel;
            state_ff <= ST_RUN;
          end
        end
        ST_RUN: begin
          pre_ff <= step_end ? 8'h00 : pre_ff + 8'h01;
          if (step_end) begin
            step_ff <= step_ff + 4'h1;
            if (step_ff == N_STEPS[3:0] - 4'h1) begin
              state_ff <= ST_IDLE;
              done_ff  <= 1'b1;
            end
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
      busy_ff <= run && (step_ff <= 4'h6); // R14
      s2_ff   <= run && (step_ff >= 4'h3) && (step_ff <= 4'h4); // R14
      z_ff    <= zc_win && sel_ff[0]; // R14
      c_ff    <= zc_win && sel_ff[1]; // R14
    end
  end

endmodule

// File: hdl/ccsc_top.v
// ccsc_top: single-cycle crate controller, host i/o byte bus to crate dataway
// assumes host strobes and all dataway inputs are asynchronous to mclk
// Operation
// R1: sixteen 8-bit registers in host i/o space on the 8-bit data bus; the code maps fifteen, offset f is unused.
// R2: all sequencers are timed from a 10 MHz step derived from mclk.
// R3: normal cycle lasts 1 us, driving S1, S2, busy and bus enables.
// R4: normal sequencer advances one step every 100 ns.
// R5: host read of status register starts a normal cycle.
// R6: peripheral ready stretches the triggering read for the 1 us cycle.
// R7: status of the finished cycle is latched and returned in that read.
// R8: host writes 24-bit write data in three bytes, low byte first.
// R9: host loads station, sub-address and function in three writes.
// R10: read data is captured in three bytes and read back afterwards.
// R11: no-data functions run without touching data registers.
// R12: writing the zero/clear/inhibit register starts a compressed cycle.
// R13: peripheral ready stretches that write for the 800 ns cycle.
// R14: compressed cycle drives busy, S2 and either Z or C; the code drives Z and C together when both bits are set.
// R15: highest priority LAM number goes to the LAM register; host interrupted.
// R16: block channel also requests normal cycles without host i/o.
// R17: block command from software or hardware trigger; data moves by DMA.
// R18: front-panel trigger or dummy read starts the block channel.
// R19: ready released only once the cycle ends and status is valid.
`timescale 1ns/100ps
`include "ccsc_regs.vh"

module ccsc_top #(
  parameter N_LAM = 24
) (
  // clock and reset
  input  wire              mclk,
  input  wire              reset,
  // host i/o bus
  input  wire [3:0]        host_addr,
  input  wire              host_ior_n,
  input  wire              host_iow_n,
  input  wire [7:0]        host_din,
  output reg  [7:0]        host_dout_ff,
  output reg               host_doe_ff,
  output reg               periph_rdy_ff,
  output reg               host_irq_ff,
  output reg               dma_req_ff,
  input  wire              dma_ack,
  input  wire              ext_trig,
  // dataway
  output reg  [7:0]        dw_station_ff,
  output reg  [7:0]        dw_subaddr_ff,
  output reg  [7:0]        dw_function_ff,
  output reg               dw_naf_oe_ff,
  output reg  [23:0]       dw_wdata_ff,
  output reg               dw_wdata_oe_ff,
  output reg               dw_busy_ff,
  output reg               dw_s1_ff,
  output reg               dw_s2_ff,
  output reg               dw_z_ff,
  output reg               dw_c_ff,
  output reg               dw_inhibit_ff,
  input  wire [23:0]       dw_rdata,
  input  wire              dw_q,
  input  wire              dw_x,
  input  wire [N_LAM-1:0]  dw_lam
);

  localparam STEP_CYC = (`CCSC_STEP_NS + `CCSC_CLK_NS - 1) / `CCSC_CLK_NS;
  localparam N_NORM   = `CCSC_NORM_NS / `CCSC_STEP_NS;
  localparam N_COMP   = `CCSC_COMP_NS / `CCSC_STEP_NS;
  localparam SW       = 1 + 4 + 1 + 1 + 8 + 1 + 24 + 1 + 1 + N_LAM;

  localparam B_IDLE = 4'b0001;
  localparam B_CYC  = 4'b0010;
  localparam B_DMA  = 4'b0100;
  localparam B_WAIT = 4'b1000;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  reg  [SW-1:0] sync1_ff;
  reg  [SW-1:0] sync2_ff;
  reg           ior_d_ff;
  reg           iow_d_ff;
  reg           trig_d_ff;
  reg           ack_d_ff;
  wire [3:0]    a_s;
  wire          ior_s;
  wire          iow_s;
  wire [7:0]    din_s;
  wire          trig_s;
  wire [23:0]   rd_s;
  wire          q_s;
  wire          x_s;
  wire [N_LAM-1:0] lam_s;
  wire          ack_s;

  assign {a_s, ior_s, iow_s, din_s, trig_s, rd_s, q_s, x_s, lam_s} = sync2_ff[SW-2:0];
  assign ack_s = sync2_ff[SW-1];

  wire rd_fall = ior_d_ff && !ior_s;
  wire wr_fall = iow_d_ff && !iow_s;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [7:0]  wd_low_ff, wd_mid_ff, wd_high_ff;
  reg [7:0]  station_ff, subaddr_ff, function_ff;
  reg [7:0]  rd_low_ff, rd_mid_ff, rd_high_ff;
  reg        q_ff, x_ff, inhibit_ff, blk_done_ff;
  reg [7:0]  lam_num_ff;
  reg [7:0]  blk_count_ff, blk_left_ff;
  reg [3:0]  bstate_ff;
  reg [1:0]  byte_ff;
  reg        host_pend_ff, host_cyc_ff, comp_pend_ff;
  reg        norm_start_ff, comp_start_ff;
  reg [1:0]  zc_ff;

  wire n_busy, n_s1, n_s2, n_naf, n_wd, n_latch, n_done;
  wire c_busy, c_s2, c_z, c_c, c_done;
  reg  n_active_ff;

  // functions reading or writing data need the dataway data bus
  function is_read;
    input [7:0] f;
    begin
      is_read = (f[4:3] == 2'b00);
    end
  endfunction

  function is_write;
    input [7:0] f;
    begin
      is_write = (f[4:3] == 2'b10);
    end
  endfunction

  // lowest lam line wins; 0 means none pending
  function [7:0] lam_pri;
    input [N_LAM-1:0] v;
    integer i;
    begin
      lam_pri = 8'h00;
      for (i = N_LAM - 1; i >= 0; i = i - 1) begin
        if (v[i]) begin
          lam_pri = i[7:0] + 8'h01;
        end
      end
    end
  endfunction

  wire [7:0] status_v = {2'b00, inhibit_ff, |lam_s, blk_done_ff,
                         !bstate_ff[0], x_ff, q_ff};

  function [7:0] rd_mux;
    input [3:0] a;
    begin
      case (a)
        `CCSC_OFS_RDATA_LOW:  rd_mux = rd_low_ff;
        `CCSC_OFS_RDATA_MID:  rd_mux = rd_mid_ff;
        `CCSC_OFS_RDATA_HIGH: rd_mux = rd_high_ff;
        `CCSC_OFS_STATUS:     rd_mux = status_v;
        `CCSC_OFS_LAM:        rd_mux = lam_num_ff;
        `CCSC_OFS_BLK_COUNT:  rd_mux = blk_count_ff;
        `CCSC_OFS_BLK_STATUS: rd_mux = status_v;
        default:              rd_mux = 8'h00;
      endcase
    end
  endfunction

  wire blk_trig = (rd_fall && a_s == `CCSC_OFS_BLK_START) || (!trig_d_ff && trig_s); // R18
  wire seq_free = !n_active_ff && !norm_start_ff;
  wire blk_go   = bstate_ff[1] && seq_free && !host_pend_ff && !n_done;
  wire blk_data = is_read(function_ff) || is_write(function_ff);

  // ----------------------------------------------------------------
  // sequencers
  // ----------------------------------------------------------------
  ccsc_norm_seq #(
    .STEP_CYC (STEP_CYC),
    .N_STEPS  (N_NORM)
  ) u_norm (
    .mclk      (mclk),
    .reset     (reset),
    .start     (norm_start_ff),
    .wr_fn     (is_write(function_ff)),
    .busy_ff   (n_busy),
    .s1_ff     (n_s1),
    .s2_ff     (n_s2),
    .naf_oe_ff (n_naf),
    .wd_oe_ff  (n_wd),
    .latch_ff  (n_latch),
    .done_ff   (n_done)
  );

  ccsc_comp_seq #(
    .STEP_CYC (STEP_CYC),
    .N_STEPS  (N_COMP)
  ) u_comp (
    .mclk    (mclk),
    .reset   (reset),
    .start   (comp_start_ff),
    .zc_sel  (zc_ff),
    .busy_ff (c_busy),
    .s2_ff   (c_s2),
    .z_ff    (c_z),
    .c_ff    (c_c),
    .done_ff (c_done)
  );

  // ----------------------------------------------------------------
  // main clocked logic
  // ----------------------------------------------------------------
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      sync1_ff       <= {SW{1'b0}};
      sync2_ff       <= {SW{1'b0}};
      // start low: synchroniser zeros after reset must not look like a strobe fall
      ior_d_ff       <= 1'b0;
      iow_d_ff       <= 1'b0;
      trig_d_ff      <= 1'b0;
      ack_d_ff       <= 1'b0;
      wd_low_ff      <= `CCSC_RST_BYTE;
      wd_mid_ff      <= `CCSC_RST_BYTE;
      wd_high_ff     <= `CCSC_RST_BYTE;
      station_ff     <= `CCSC_RST_BYTE;
      subaddr_ff     <= `CCSC_RST_BYTE;
      function_ff    <= `CCSC_RST_BYTE;
      rd_low_ff      <= `CCSC_RST_BYTE;
      rd_mid_ff      <= `CCSC_RST_BYTE;
      rd_high_ff     <= `CCSC_RST_BYTE;
      q_ff           <= 1'b0;
      x_ff           <= 1'b0;
      inhibit_ff     <= 1'b0;
      blk_done_ff    <= 1'b0;
      lam_num_ff     <= `CCSC_RST_BYTE;
      blk_count_ff   <= `CCSC_RST_BLK_COUNT;
      blk_left_ff    <= `CCSC_RST_BYTE;
      bstate_ff      <= B_IDLE;
      byte_ff        <= 2'b00;
      host_pend_ff   <= 1'b0;
      host_cyc_ff    <= 1'b0;
      comp_pend_ff   <= 1'b0;
      norm_start_ff  <= 1'b0;
      comp_start_ff  <= 1'b0;
      zc_ff          <= 2'b00;
      n_active_ff    <= 1'b0;
      host_dout_ff   <= 8'h00;
      host_doe_ff    <= 1'b0;
      periph_rdy_ff  <= 1'b0;
      host_irq_ff    <= 1'b0;
      dma_req_ff     <= 1'b0;
      dw_station_ff  <= 8'h00;
      dw_subaddr_ff  <= 8'h00;
      dw_function_ff <= 8'h00;
      dw_naf_oe_ff   <= 1'b0;
      dw_wdata_ff    <= 24'h000000;
      dw_wdata_oe_ff <= 1'b0;
      dw_busy_ff     <= 1'b0;
      dw_s1_ff       <= 1'b0;
      dw_s2_ff       <= 1'b0;
      dw_z_ff        <= 1'b0;
      dw_c_ff        <= 1'b0;
      dw_inhibit_ff  <= 1'b0;
    end else begin
      sync1_ff      <= {dma_ack, host_addr, host_ior_n, host_iow_n, host_din, ext_trig,
                        dw_rdata, dw_q, dw_x, dw_lam};
      sync2_ff      <= sync1_ff;
      ior_d_ff      <= ior_s;
      iow_d_ff      <= iow_s;
      trig_d_ff     <= trig_s;
      ack_d_ff      <= ack_s;
      norm_start_ff <= 1'b0;
      comp_start_ff <= 1'b0;

      // host register writes
      if (wr_fall) begin
        case (a_s)
          `CCSC_OFS_WDATA_LOW:  wd_low_ff    <= din_s; // R8
          `CCSC_OFS_WDATA_MID:  wd_mid_ff    <= din_s; // R8
          `CCSC_OFS_WDATA_HIGH: wd_high_ff   <= din_s; // R8
          `CCSC_OFS_STATION:    station_ff   <= din_s; // R9
          `CCSC_OFS_SUBADDR:    subaddr_ff   <= din_s; // R9
          `CCSC_OFS_FUNCTION:   function_ff  <= din_s; // R9
          `CCSC_OFS_BLK_COUNT:  blk_count_ff <= din_s;
          `CCSC_OFS_ZCI_CMD: begin
            inhibit_ff    <= din_s[`CCSC_ZCI_I];
            zc_ff         <= {din_s[`CCSC_ZCI_C], din_s[`CCSC_ZCI_Z]};
            comp_pend_ff  <= 1'b1; // R12
            periph_rdy_ff <= 1'b1; // R13
          end
          default: begin
          end
        endcase
      end

      // host register reads; status read waits for its cycle
      if (rd_fall && !bstate_ff[2]) begin
        host_doe_ff <= 1'b1;
        if (a_s == `CCSC_OFS_STATUS) begin
          host_pend_ff  <= 1'b1; // R5
          periph_rdy_ff <= 1'b1; // R6
        end else begin
          host_dout_ff <= rd_mux(a_s); // R1
        end
      end else if (ior_s && !bstate_ff[2]) begin
        host_doe_ff <= 1'b0;
      end

      // compressed cycle: start, then release the stretched write
      if (comp_pend_ff && seq_free && !c_busy && !host_pend_ff) begin
        comp_pend_ff  <= 1'b0;
        comp_start_ff <= 1'b1;
      end
      if (c_done) begin
        periph_rdy_ff <= 1'b0; // R19
      end

      // normal cycle arbitration, host first
      if (n_done) begin
        n_active_ff <= 1'b0;
      end
      if (seq_free && !comp_pend_ff && !comp_start_ff && host_pend_ff) begin
        host_pend_ff  <= 1'b0;
        host_cyc_ff   <= 1'b1;
        norm_start_ff <= 1'b1;
        n_active_ff   <= 1'b1;
      end else if (blk_go && !comp_pend_ff && !comp_start_ff) begin
        norm_start_ff <= 1'b1; // R16
        n_active_ff   <= 1'b1;
      end

      // latch dataway answer at the strobe
      if (n_latch) begin
        q_ff <= q_s;
        x_ff <= x_s;
        if (is_read(function_ff)) begin
          {rd_high_ff, rd_mid_ff, rd_low_ff} <= rd_s; // R10
        end
      end
      if (n_done && host_cyc_ff) begin
        host_cyc_ff   <= 1'b0;
        host_dout_ff  <= status_v; // R7
        periph_rdy_ff <= 1'b0; // R19
      end

      // block channel
      case (bstate_ff)
        B_IDLE: begin
          if (blk_trig) begin
            blk_done_ff <= 1'b0;
            blk_left_ff <= blk_count_ff;
            bstate_ff   <= B_CYC; // R17
          end
        end
        B_CYC: begin
          if (n_done && !host_cyc_ff) begin
            byte_ff   <= 2'b00;
            bstate_ff <= blk_data ? B_DMA : B_WAIT;
          end
        end
        B_DMA: begin
          dma_req_ff <= !ack_s; // R17
          if (ack_s && !ack_d_ff) begin
            host_doe_ff  <= is_read(function_ff);
            host_dout_ff <= (byte_ff == 2'b00) ? rd_low_ff :
                            (byte_ff == 2'b01) ? rd_mid_ff : rd_high_ff;
          end
          if (ack_s && wr_fall) begin
            case (byte_ff)
              2'b00:   wd_low_ff  <= din_s;
              2'b01:   wd_mid_ff  <= din_s;
              default: wd_high_ff <= din_s;
            endcase
          end
          if (!ack_s && ack_d_ff) begin
            host_doe_ff <= 1'b0;
            byte_ff     <= byte_ff + 2'b01;
            if (byte_ff == 2'b10) begin
              dma_req_ff <= 1'b0;
              bstate_ff  <= B_WAIT;
            end
          end
        end
        B_WAIT: begin
          if (blk_left_ff <= 8'h01) begin
            blk_done_ff <= 1'b1;
            bstate_ff   <= B_IDLE;
          end else begin
            blk_left_ff <= blk_left_ff - 8'h01;
            bstate_ff   <= B_CYC;
          end
        end
        default: begin
          bstate_ff <= B_IDLE;
        end
      endcase

      // lam priority and interrupt
      lam_num_ff  <= lam_pri(lam_s); // R15
      host_irq_ff <= |lam_s || blk_done_ff; // R15

      // dataway outputs
      dw_station_ff  <= station_ff;
      dw_subaddr_ff  <= subaddr_ff;
      dw_function_ff <= function_ff;
      dw_wdata_ff    <= {wd_high_ff, wd_mid_ff, wd_low_ff};
      dw_naf_oe_ff   <= n_naf; // R3
      dw_wdata_oe_ff <= n_wd && is_write(function_ff); // R11
      dw_busy_ff     <= n_busy || c_busy; // R2
      dw_s1_ff       <= n_s1;
      dw_s2_ff       <= n_s2 || c_s2;
      dw_z_ff        <= c_z;
      dw_c_ff        <= c_c;
      dw_inhibit_ff  <= inhibit_ff;
    end
  end

endmodule

// File: verif/ccsc_props.sv
// ccsc_props: port timing checks for the crate controller
// assumes bind onto ccsc_top, mclk at 100 MHz
`timescale 1ns/100ps
`include "ccsc_regs.vh"
module ccsc_props (
  // clock and reset
  input wire       mclk,
  input wire       reset,
  // watched ports
  input wire [3:0] host_addr,
  input wire       host_ior_n,
  input wire       periph_rdy_ff,
  input wire       dw_busy_ff,
  input wire       dw_s1_ff,
  input wire       dw_s2_ff,
  input wire       dw_z_ff
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  chk_s1_in_busy: assert property (dw_s1_ff |-> dw_busy_ff)
    else $error("s1 outside busy");
  chk_s2_in_busy: assert property (dw_s2_ff |-> dw_busy_ff)
    else $error("s2 outside busy");
  chk_s1_two_steps: assert property ($rose(dw_s1_ff) |-> ##19 dw_s1_ff ##1 !dw_s1_ff)
    else $error("s1 width wrong");
  chk_s2_after_s1: assert property ($fell(dw_s1_ff) |-> ##[18:22] $rose(dw_s2_ff))
    else $error("s2 spacing wrong");
  chk_status_start: assert property ($fell(host_ior_n) && host_addr == `CCSC_OFS_STATUS
    |-> ##[3:5] $rose(periph_rdy_ff))
    else $error("status read did not stretch");
  chk_rdy_runs: assert property ($rose(periph_rdy_ff) |-> ##[1:4] $rose(dw_busy_ff))
    else $error("no cycle in stretch");
  chk_rdy_length: assert property ($rose(periph_rdy_ff) |->
    (periph_rdy_ff throughout (##69 1'b1)) ##[1:41] !periph_rdy_ff)
    else $error("stretch length wrong");
  chk_z_in_comp: assert property (dw_z_ff |-> periph_rdy_ff && !dw_s1_ff)
    else $error("z outside compressed cycle");
  chk_rdy_release: assert property ($fell(periph_rdy_ff) |-> !dw_busy_ff)
    else $error("ready released while busy");
endmodule
bind ccsc_top ccsc_props u_props (.mclk(mclk), .reset(reset), .host_addr(host_addr),
  .host_ior_n(host_ior_n), .periph_rdy_ff(periph_rdy_ff), .dw_busy_ff(dw_busy_ff),
  .dw_s1_ff(dw_s1_ff), .dw_s2_ff(dw_s2_ff), .dw_z_ff(dw_z_ff));

// File: verif/ccsc_dw_model.sv
// ccsc_dw_model: behavioural crate modules on the dataway
// assumes the bench sets the lam lines
`timescale 1ns/100ps
module ccsc_dw_model (
  input  wire [7:0]  dw_station_ff,
  input  wire        dw_busy_ff,
  input  wire [23:0] lam_set,
  output wire [23:0] dw_rdata,
  output wire        dw_q,
  output wire        dw_x,
  output wire [23:0] dw_lam
);
  wire [23:0] rd = {8'hc3, 8'h5a, dw_station_ff};
  wire        qv = (dw_station_ff != 8'h00);
  // outside busy rdata and q show the inverse and x is low, never a stale match
  assign dw_rdata = dw_busy_ff ? rd : ~rd;
  assign dw_q     = dw_busy_ff ? qv : ~qv;
  assign dw_x     = dw_busy_ff;
  assign dw_lam   = lam_set;
endmodule

// File: verif/tb_top.sv
// tb_top: host i/o sequences against the crate controller
// assumes ccsc_top with the dataway model on its far side
`timescale 1ns/100ps
module tb_top;
  reg         mclk, reset, ior_n, iow_n;
  reg  [3:0]  addr;
  reg  [7:0]  din, d;
  reg  [23:0] lam_set;
  integer     error_cnt, cmp_count, i, oe_n, z_n, c_n, k;
  wire [7:0]  dout, st, sa, fn;
  wire [23:0] rdata, lam, wd;
  wire        rdy, irq, busy, q, x, z, c, wd_oe, inh;
  ccsc_top u_dut (.mclk(mclk), .reset(reset), .host_addr(addr), .host_ior_n(ior_n),
    .host_iow_n(iow_n), .host_din(din), .host_dout_ff(dout), .host_doe_ff(),
    .periph_rdy_ff(rdy), .host_irq_ff(irq), .dma_req_ff(), .dma_ack(1'b0),
    .ext_trig(1'b0), .dw_station_ff(st), .dw_subaddr_ff(sa), .dw_function_ff(fn),
    .dw_naf_oe_ff(), .dw_wdata_ff(wd), .dw_wdata_oe_ff(wd_oe), .dw_busy_ff(busy),
    .dw_s1_ff(), .dw_s2_ff(), .dw_z_ff(z), .dw_c_ff(c), .dw_inhibit_ff(inh),
    .dw_rdata(rdata), .dw_q(q), .dw_x(x), .dw_lam(lam));
  ccsc_dw_model u_dw (.dw_station_ff(st), .dw_busy_ff(busy), .lam_set(lam_set),
    .dw_rdata(rdata), .dw_q(q), .dw_x(x), .dw_lam(lam));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    oe_n <= oe_n + wd_oe;
    z_n <= z_n + z;
    c_n <= c_n + c;
  end
  // ------------------------------------------------
  // host access tasks
  // ------------------------------------------------
  task chk(input string nm, input [23:0] e, input [23:0] g);
    begin
      cmp_count = cmp_count + 1;
      if (g !== e) begin
        error_cnt = error_cnt + 1;
        $display("[ERR] %s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task results;
    begin
      if (error_cnt == 0 && cmp_count > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  // strobe stays low until the stretch ends
  task hold_rdy;
    begin
      repeat (6) @(posedge mclk);
      #1;
      i = 0;
      while (rdy !== 1'b0 && i < 300) begin
        @(posedge mclk);
        #1;
        i = i + 1;
      end
      if (i == 300) begin
        error_cnt = error_cnt + 1;
        results;
      end
    end
  endtask
  task wr(input [3:0] a, input [7:0] v);
    begin
      @(posedge mclk);
      addr <= a;
      din <= v;
      iow_n <= 1'b0;
      hold_rdy;
      @(posedge mclk);
      iow_n <= 1'b1;
      repeat (5) @(posedge mclk);
    end
  endtask
  task rd(input [3:0] a);
    begin
      @(posedge mclk);
      addr <= a;
      ior_n <= 1'b0;
      hold_rdy;
      d = dout;
      @(posedge mclk);
      ior_n <= 1'b1;
      repeat (5) @(posedge mclk);
    end
  endtask
  task cyc(input [7:0] n, input [7:0] f, input [7:0] e);
    begin
      wr(4'h3, n);
      wr(4'h4, 8'h01);
      wr(4'h5, f);
      rd(4'h9);
      chk("status", e, d);
    end
  endtask
  // ------------------------------------------------
  // main sequence
  // ------------------------------------------------
  initial begin
    reset = 1'b1;
    ior_n = 1'b1;
    iow_n = 1'b1;
    addr = 4'h0;
    din = 8'h00;
    lam_set = 24'h000000;
    {error_cnt, cmp_count, oe_n, z_n, c_n} = 0;
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    repeat (3) @(posedge mclk);
    rd(4'h6);
    chk("rdata_rst", 8'h00, d);
    wr(4'h0, 8'h11);
    wr(4'h1, 8'h22);
    wr(4'h2, 8'h33);
    cyc(8'h05, 8'h10, 8'h03);
    chk("wdata", 24'h332211, wd);
    chk("naf", 24'h050110, {st, sa, fn});
    chk("wdata_oe", 90, oe_n);
    cyc(8'h05, 8'h00, 8'h03);
    for (k = 0; k < 3; k = k + 1) begin
      rd(4'h6 + k[3:0]);
      chk("rdata", ({8'hc3, 8'h5a, 8'h05} >> (8 * k)) & 24'h0000ff, {16'h0, d});
    end
    k = oe_n;
    cyc(8'h00, 8'h08, 8'h02);
    chk("no_data_oe", k, oe_n);
    wr(4'ha, 8'h01);
    chk("z_len", 60, z_n);
    wr(4'ha, 8'h06);
    chk("c_len", 60, c_n);
    chk("inhibit", 1, inh);
    rd(4'h3);
    chk("wo_read", 8'h00, d);
    rd(4'hf);
    chk("unmapped", 8'h00, d);
    lam_set <= 24'h000088;
    rd(4'hb);
    chk("lam_num", 8'h04, d);
    chk("irq_on", 1'b1, irq);
    lam_set <= 24'h000000;
    repeat (8) @(posedge mclk);
    chk("irq_off", 1'b0, irq);
    rd(4'hd);
    repeat (100) @(posedge mclk);
    chk("irq_blk", 1'b1, irq);
    cyc(8'h00, 8'h08, 8'h2a);
    results;
  end
endmodule
